// ### config_word_pkg.sv
// Constants shared by the configuration word store
//
// Function
// RULE_01: Programmed bit reads zero, erased reads one
// RULE_02: Configuration words start at fixed base
// RULE_03: Only table accesses reach configuration space
// RULE_04: Eight words at fixed even addresses
// RULE_05: Code 111 disables boot; reserved codes refused
// RULE_06: Codes 110/010 give small boot segment
// RULE_07: Codes 101/001 give large boot segment
// RULE_08: Write-lock bit zero blocks boot writes
// RULE_09: Boot word upper four bits read zero
// RULE_10: Words latched at reset, held while running
package config_word_pkg;

    localparam int ADDR_W = 24;
    localparam int WORD_W = 8;
    localparam int NUM_WORDS = 8;
    localparam int IDX_W = 3;

    // Configuration space and word addresses
    localparam logic [23:0] CFG_SPACE_LO = 24'h800000;
    localparam logic [23:0] CFG_SPACE_HI = 24'hFFFFFF;
    localparam logic [23:0] CFG_BASE = 24'hF80000;
    localparam logic [23:0] BOOT_SEGMENT_CONFIG_ADDR = 24'hF80000;
    localparam logic [23:0] GENERAL_SEGMENT_CONFIG_ADDR = 24'hF80004;
    localparam logic [23:0] OSCILLATOR_SELECT_CONFIG_ADDR = 24'hF80006;
    localparam logic [23:0] OSCILLATOR_CONFIG_ADDR = 24'hF80008;
    localparam logic [23:0] WATCHDOG_CONFIG_ADDR = 24'hF8000A;
    localparam logic [23:0] POWER_ON_RESET_CONFIG_ADDR = 24'hF8000C;
    localparam logic [23:0] DEBUGGER_CONFIG_ADDR = 24'hF8000E;
    localparam logic [23:0] DEEP_SLEEP_CONFIG_ADDR = 24'hF80010;

    // Word indices in the store
    localparam logic [2:0] IDX_BOOT = 3'h0;
    localparam logic [2:0] IDX_GENERAL = 3'h1;
    localparam logic [2:0] IDX_OSC_SEL = 3'h2;
    localparam logic [2:0] IDX_OSC = 3'h3;
    localparam logic [2:0] IDX_WATCHDOG = 3'h4;
    localparam logic [2:0] IDX_POR = 3'h5;
    localparam logic [2:0] IDX_DEBUG = 3'h6;
    localparam logic [2:0] IDX_DEEP_SLEEP = 3'h7;

    // Boot segment word fields
    localparam int BOOT_WRITE_LOCK_BIT = 0;
    localparam int BOOT_PROTECT_SEL_LSB = 1;
    localparam int BOOT_PROTECT_SEL_MSB = 3;
    localparam logic [7:0] BOOT_WORD_IMPL_MASK = 8'h0F;

    // Erased value of every word; the boot word keeps only its low four bits
    localparam logic [7:0] ERASED_WORD = 8'hFF;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // Boot protection codes
    localparam logic [2:0] BSEL_NONE = 3'h7;
    localparam logic [2:0] BSEL_STD_SMALL = 3'h6;
    localparam logic [2:0] BSEL_HIGH_SMALL = 3'h2;
    localparam logic [2:0] BSEL_STD_LARGE = 3'h5;
    localparam logic [2:0] BSEL_HIGH_LARGE = 3'h1;
    localparam logic [2:0] BSEL_RSVD_A = 3'h3;
    localparam logic [2:0] BSEL_RSVD_B = 3'h4;
    localparam logic [2:0] BSEL_RSVD_C = 3'h0;

    // Boot segment bounds, program word addresses
    localparam logic [23:0] BOOT_SEG_START = 24'h000200;
    localparam logic [23:0] BOOT_SEG_END_SMALL = 24'h000AFE;
    localparam logic [23:0] BOOT_SEG_END_LARGE = 24'h0015FE;

endpackage : config_word_pkg

// ### config_word_boot_protect.sv
// Configuration word store with boot segment protection decode
`timescale 1ns/10ps
`default_nettype none
module config_word_boot_protect (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        tbl_rd,
    input  wire logic        tbl_wr,
    input  wire logic [23:0] tbl_addr,
    input  wire logic [7:0]  tbl_wdata,
    input  wire logic        nv_erase,
    input  wire logic        core_req,
    input  wire logic [23:0] core_addr,
    input  wire logic        flash_wr_req,
    input  wire logic [23:0] flash_wr_addr,
    output logic      [7:0]  tbl_rdata,
    output logic             tbl_rvalid,
    output logic             tbl_wack,
    output logic             tbl_werr,
    output logic             core_cfg_reject,
    output logic             flash_wr_blocked,
    output logic             boot_seg_present,
    output logic             boot_seg_high_sec,
    output logic      [23:0] boot_seg_end,
    output logic             boot_write_lock,
    output logic      [63:0] cfg_words
);

    typedef struct packed {
        logic [7:0][7:0] nv;
        logic [7:0][7:0] lat;
        logic [7:0]      rdata;
        logic            rvalid;
        logic            wack;
        logic            werr;
        logic            reject;
        logic            wr_blocked;
        logic            present;
        logic            high_sec;
        logic [23:0]     seg_end;
        logic            wlock;
    } state_s;

    state_s st_r;
    state_s st_nxt;

    // Maps a table address to a word index; odd or gap addresses miss
    function automatic logic [3:0] addr_to_idx(input logic [23:0] a);
        logic [3:0] r;
        r = 4'h0;
        case (a)
            // Fixed word locations
            config_word_pkg::BOOT_SEGMENT_CONFIG_ADDR:
                r = {1'b1, config_word_pkg::IDX_BOOT};
            config_word_pkg::GENERAL_SEGMENT_CONFIG_ADDR:
                r = {1'b1, config_word_pkg::IDX_GENERAL};
            config_word_pkg::OSCILLATOR_SELECT_CONFIG_ADDR:
                r = {1'b1, config_word_pkg::IDX_OSC_SEL};
            config_word_pkg::OSCILLATOR_CONFIG_ADDR:
                r = {1'b1, config_word_pkg::IDX_OSC};
            config_word_pkg::WATCHDOG_CONFIG_ADDR:
                r = {1'b1, config_word_pkg::IDX_WATCHDOG};
            config_word_pkg::POWER_ON_RESET_CONFIG_ADDR:
                r = {1'b1, config_word_pkg::IDX_POR};
            config_word_pkg::DEBUGGER_CONFIG_ADDR:
                r = {1'b1, config_word_pkg::IDX_DEBUG};
            config_word_pkg::DEEP_SLEEP_CONFIG_ADDR:
                r = {1'b1, config_word_pkg::IDX_DEEP_SLEEP};
            default:
                r = 4'h0;
        endcase
        return r;
    endfunction : addr_to_idx

    // Unimplemented bits of the boot word never hold a one
    function automatic logic [7:0] word_mask(input logic [2:0] idx,
                                             input logic [7:0] w);
        logic [7:0] r;
        r = w;
        // RULE_09 upper bits zero
        if (idx == config_word_pkg::IDX_BOOT) begin
            r = w & config_word_pkg::BOOT_WORD_IMPL_MASK;
        end
        return r;
    endfunction : word_mask

    function automatic logic [2:0] sel_of(input logic [7:0] w);
        return w[config_word_pkg::BOOT_PROTECT_SEL_MSB:
                 config_word_pkg::BOOT_PROTECT_SEL_LSB];
    endfunction : sel_of

    function automatic logic sel_reserved(input logic [2:0] s);
        return (s == config_word_pkg::BSEL_RSVD_A) ||
               (s == config_word_pkg::BSEL_RSVD_B) ||
               (s == config_word_pkg::BSEL_RSVD_C);
    endfunction : sel_reserved

    // Decodes protection code into {present, high, end address}
    function automatic logic [25:0] decode_sel(input logic [2:0] s);
        logic [25:0] r;
        r = {1'b0, 1'b0, config_word_pkg::BOOT_SEG_START};
        case (s)
            // RULE_06 small segment
            config_word_pkg::BSEL_STD_SMALL:
                r = {1'b1, 1'b0, config_word_pkg::BOOT_SEG_END_SMALL};
            config_word_pkg::BSEL_HIGH_SMALL:
                r = {1'b1, 1'b1, config_word_pkg::BOOT_SEG_END_SMALL};
            // RULE_07 large segment
            config_word_pkg::BSEL_STD_LARGE:
                r = {1'b1, 1'b0, config_word_pkg::BOOT_SEG_END_LARGE};
            config_word_pkg::BSEL_HIGH_LARGE:
                r = {1'b1, 1'b1, config_word_pkg::BOOT_SEG_END_LARGE};
            // RULE_05 all ones disables
            config_word_pkg::BSEL_NONE:
                r = {1'b0, 1'b0, config_word_pkg::BOOT_SEG_START};
            default:
                // Reserved code stored anyway: safest to treat as absent
                r = {1'b0, 1'b0, config_word_pkg::BOOT_SEG_START};
        endcase
        return r;
    endfunction : decode_sel

    // Loads the latched copy and its decode from the store
    function automatic state_s latch_from_nv(input state_s s);
        state_s r;
        logic [25:0] d;
        r = s;
        // RULE_10 latch during reset
        r.lat = s.nv;
        d = decode_sel(sel_of(s.nv[config_word_pkg::IDX_BOOT]));
        r.present = d[25];
        r.high_sec = d[24];
        r.seg_end = d[23:0];
        r.wlock =
            ~s.nv[config_word_pkg::IDX_BOOT]
                 [config_word_pkg::BOOT_WRITE_LOCK_BIT];
        r.rdata = config_word_pkg::READ_ZERO;
        r.rvalid = 1'b0;
        r.wack = 1'b0;
        r.werr = 1'b0;
        r.reject = 1'b0;
        r.wr_blocked = 1'b0;
        return r;
    endfunction : latch_from_nv

    always_comb begin
        logic [3:0] hit;
        logic [7:0] wval;
        logic       in_cfg_tbl;
        logic       in_cfg_core;
        logic       in_seg;
        hit = addr_to_idx(tbl_addr);
        wval = word_mask(hit[2:0], tbl_wdata);
        // RULE_02 base in config space
        in_cfg_tbl = (tbl_addr >= config_word_pkg::CFG_BASE);
        in_cfg_core = (core_addr >= config_word_pkg::CFG_SPACE_LO) &&
                      (core_addr <= config_word_pkg::CFG_SPACE_HI);
        in_seg = (flash_wr_addr >= config_word_pkg::BOOT_SEG_START) &&
                 (flash_wr_addr <= st_r.seg_end);
        st_nxt = st_r;
        st_nxt.rvalid = 1'b0;
        st_nxt.wack = 1'b0;
        st_nxt.werr = 1'b0;

        // RULE_03 fetch and data refused
        st_nxt.reject = core_req && in_cfg_core;

        // RULE_04 table read of a word
        if (tbl_rd) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata = config_word_pkg::READ_ZERO;
            if (hit[3] && in_cfg_tbl) begin
                // RULE_09 boot word masked
                st_nxt.rdata = word_mask(hit[2:0], st_r.nv[hit[2:0]]);
            end
        end else if (tbl_wr) begin
            st_nxt.wack = 1'b1;
            if (!hit[3]) begin
                st_nxt.werr = 1'b1;
            // RULE_05 reserved code refused
            end else if (hit[2:0] == config_word_pkg::IDX_BOOT &&
                         sel_reserved(sel_of(wval))) begin
                st_nxt.werr = 1'b1;
            end else begin
                // RULE_01 zero is programmed
                st_nxt.nv[hit[2:0]] = wval;
            end
        end

        // Erase returns every implemented bit to its unprogrammed one
        if (nv_erase) begin
            for (int i = 0; i < config_word_pkg::NUM_WORDS; i++) begin
                st_nxt.nv[i] = word_mask(3'(i),
                                         config_word_pkg::ERASED_WORD);
            end
        end

        // RULE_08 write lock blocks segment
        st_nxt.wr_blocked = flash_wr_req && st_r.present &&
                            st_r.wlock && in_seg;
    end

    // Store survives reset; the latched copy and its decode are refreshed by it
    always_ff @(posedge clk) begin
        if (reset) begin
            st_r <= latch_from_nv(st_r);
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tbl_rdata = st_r.rdata;
    assign tbl_rvalid = st_r.rvalid;
    assign tbl_wack = st_r.wack;
    assign tbl_werr = st_r.werr;
    assign core_cfg_reject = st_r.reject;
    assign flash_wr_blocked = st_r.wr_blocked;
    assign boot_seg_present = st_r.present;
    assign boot_seg_high_sec = st_r.high_sec;
    assign boot_seg_end = st_r.seg_end;
    assign boot_write_lock = st_r.wlock;
    assign cfg_words = st_r.lat;

endmodule : config_word_boot_protect
`default_nettype wire

// ### cfg_store_checker.sv
// Port checker for the configuration store
`timescale 1ns/10ps
`default_nettype none
module cfg_store_checker (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        tbl_rd,
    input wire logic        tbl_wr,
    input wire logic [23:0] tbl_addr,
    input wire logic [7:0]  tbl_rdata,
    input wire logic        tbl_rvalid,
    input wire logic        tbl_wack,
    input wire logic        core_req,
    input wire logic [23:0] core_addr,
    input wire logic        core_cfg_reject,
    input wire logic        flash_wr_req,
    input wire logic [23:0] flash_wr_addr,
    input wire logic        flash_wr_blocked,
    input wire logic        boot_seg_present,
    input wire logic        boot_seg_high_sec,
    input wire logic [23:0] boot_seg_end,
    input wire logic        boot_write_lock,
    input wire logic [63:0] cfg_words
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence lock_hit_s;
        flash_wr_req && boot_seg_present && boot_write_lock &&
        flash_wr_addr >= 24'h000200 && flash_wr_addr <= boot_seg_end;
    endsequence
    sequence blocked_s;
        ##1 flash_wr_blocked;
    endsequence
    // Unknown store before the first erase makes decode checks vacuous
    read_answer_a:
        assert property (tbl_rd |=> tbl_rvalid) else $error("read late");
    write_answer_a:
        assert property (tbl_wr && !tbl_rd |=> tbl_wack)
        else $error("write late");
    upper_zero_a:
        assert property (tbl_rvalid && $past(tbl_addr) == 24'hF80000 |->
            tbl_rdata[7:4] == 4'h0) else $error("boot upper bits set");
    core_reject_a:
        assert property (core_req |=> core_cfg_reject == $past(core_addr[23]))
        else $error("core reject wrong");
    seg_block_a:
        assert property (lock_hit_s |-> blocked_s) else $error("not blocked");
    no_block_a:
        assert property (!flash_wr_req |=> !flash_wr_blocked)
        else $error("stray block");
    seg_valid_a:
        assert property (boot_seg_present |->
            cfg_words[3:1] inside {3'h6, 3'h2, 3'h5, 3'h1})
        else $error("segment from bad code");
    seg_none_a:
        assert property (cfg_words[3:1] == 3'h7 |->
            !boot_seg_present && boot_seg_end == 24'h000200)
        else $error("segment not off");
    seg_end_a:
        assert property (boot_seg_present |-> boot_seg_end ==
            (cfg_words[1] ? 24'h0015FE : 24'h000AFE)) else $error("bad end");
    high_sec_a:
        assert property (boot_seg_high_sec |-> !cfg_words[3])
        else $error("bad security");
    lock_bit_a:
        assert property (cfg_words[0] |-> !boot_write_lock)
        else $error("lock inverted");
    latch_held_a:
        assert property ($changed(cfg_words) |-> $past(reset))
        else $error("latched words moved");
endmodule : cfg_store_checker
`default_nettype wire

// ### core_table_model.sv
// Core-side model issuing table reads and writes
`timescale 1ns/10ps
`default_nettype none
module core_table_model (
    input  wire logic        clk,
    input  wire logic [7:0]  tbl_rdata,
    input  wire logic        tbl_rvalid,
    input  wire logic        tbl_wack,
    input  wire logic        tbl_werr,
    output var  logic        tbl_rd,
    output var  logic        tbl_wr,
    output var  logic [23:0] tbl_addr,
    output var  logic [7:0]  tbl_wdata
);
    initial {tbl_rd, tbl_wr, tbl_addr, tbl_wdata} = 34'h0;
    task automatic rd(input logic [23:0] a, output logic [8:0] r);
        @(negedge clk);
        {tbl_rd, tbl_addr} = {1'h1, a};
        @(negedge clk);
        r = {tbl_rvalid, tbl_rdata};
        // Released lines inverted so a stale address is never reused
        {tbl_rd, tbl_addr} = {1'h0, ~a};
    endtask : rd
    task automatic wr(input logic [23:0] a, input logic [7:0] v,
                      output logic [1:0] r);
        @(negedge clk);
        {tbl_wr, tbl_addr, tbl_wdata} = {1'h1, a, v};
        @(negedge clk);
        r = {tbl_wack, tbl_werr};
        {tbl_wr, tbl_addr, tbl_wdata} = {1'h0, ~a, ~v};
    endtask : wr
endmodule : core_table_model
`default_nettype wire

// ### tb_config_word_boot_protect.sv
// Self-checking bench for the configuration store
`timescale 1ns/10ps
`default_nettype none
module tb_config_word_boot_protect;
    logic        clk, reset, nv_erase, core_req, flash_wr_req, tbl_rd, tbl_wr;
    logic        tbl_rvalid, tbl_wack, tbl_werr, core_cfg_reject;
    logic        flash_wr_blocked, boot_seg_present, boot_seg_high_sec;
    logic        boot_write_lock;
    logic [23:0] tbl_addr, core_addr, flash_wr_addr, boot_seg_end, e;
    logic [7:0]  tbl_wdata, tbl_rdata;
    logic [8:0]  rr;
    logic [1:0]  wr_r;
    logic [63:0] cfg_words;
    logic [7:0]  offs [8] = '{8'h00, 8'h04, 8'h06, 8'h08, 8'h0A, 8'h0C,
                             8'h0E, 8'h10};
    logic [7:0]  rsv [3] = '{8'h01, 8'h07, 8'h09};
    logic [2:0]  codes [4] = '{3'h6, 3'h2, 3'h5, 3'h1};
    int          miscompares, checks;
    config_word_boot_protect i_dut (.clk, .reset, .tbl_rd, .tbl_wr, .tbl_addr,
        .tbl_wdata, .nv_erase, .core_req, .core_addr, .flash_wr_req,
        .flash_wr_addr, .tbl_rdata, .tbl_rvalid, .tbl_wack, .tbl_werr,
        .core_cfg_reject, .flash_wr_blocked, .boot_seg_present,
        .boot_seg_high_sec, .boot_seg_end, .boot_write_lock, .cfg_words);
    core_table_model i_core (.clk, .tbl_rdata, .tbl_rvalid, .tbl_wack,
        .tbl_werr, .tbl_rd, .tbl_wr, .tbl_addr, .tbl_wdata);
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk
    task automatic do_reset();
        @(negedge clk);
        reset = 1'h1;
        repeat (6) @(negedge clk);
        reset = 1'h0;
    endtask : do_reset
    // One strobe: core access when c is set, else a flash write
    task automatic try(input logic c, input logic [23:0] a, input logic x);
        @(negedge clk);
        {core_req, core_addr, flash_wr_req, flash_wr_addr} = {c, a, ~c, a};
        @(negedge clk);
        {core_req, flash_wr_req} = 2'h0;
        chk(c ? core_cfg_reject : flash_wr_blocked, x);
    endtask : try
    task automatic final_report();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report
    initial begin
        {reset, nv_erase, core_req, flash_wr_req} = 4'h8;
        {core_addr, flash_wr_addr} = 48'h0;
        miscompares = 0;
        checks = 0;
        // Store powers up unknown: erase it, then latch it again
        do_reset();
        @(negedge clk);
        nv_erase = 1'h1;
        @(negedge clk);
        nv_erase = 1'h0;
        do_reset();
        chk(cfg_words, 64'hFFFFFFFFFFFFFF0F);
        chk({boot_seg_present, boot_write_lock, boot_seg_end}, 64'h200);
        for (int i = 0; i < 8; i++) begin
            i_core.rd(24'hF80000 + 24'(offs[i]), rr);
            chk(rr, i == 0 ? 9'h10F : 9'h1FF);
        end
        i_core.rd(24'hF80002, rr);
        chk(rr, 9'h100);
        i_core.wr(24'hF80002, 8'h00, wr_r);
        chk(wr_r, 2'h3);
        i_core.rd(24'hF80000, rr);
        chk(rr, 9'h10F);
        for (int i = 0; i < 3; i++) begin
            i_core.wr(24'hF80000, rsv[i], wr_r);
            chk(wr_r, 2'h3);
        end
        i_core.rd(24'hF80000, rr);
        chk(rr, 9'h10F);
        for (int i = 0; i < 4; i++) begin
            i_core.wr(24'hF80000, {4'h0, codes[i], 1'h0}, wr_r);
            chk({wr_r, boot_seg_present}, {2'h2, i != 0});
            do_reset();
            e = codes[i][0] ? 24'h0015FE : 24'h000AFE;
            chk({boot_seg_present, boot_seg_high_sec, boot_write_lock,
                 boot_seg_end}, {1'h1, ~codes[i][2], 1'h1, e});
            try(1'h0, e, 1'h1);
            try(1'h0, e + 24'h2, 1'h0);
            try(1'h0, 24'h0001FE, 1'h0);
        end
        i_core.wr(24'hF80000, 8'hFD, wr_r);
        i_core.rd(24'hF80000, rr);
        chk(rr, 9'h10D);
        do_reset();
        try(1'h0, 24'h000200, 1'h0);
        i_core.wr(24'hF80004, 8'hA5, wr_r);
        i_core.rd(24'hF80004, rr);
        chk(rr, 9'h1A5);
        try(1'h1, 24'h800000, 1'h1);
        try(1'h1, 24'h7FFFFF, 1'h0);
        try(1'h1, 24'hF80000, 1'h1);
        final_report();
    end
    initial begin
        #100us;
        miscompares++;
        final_report();
    end
endmodule : tb_config_word_boot_protect
bind config_word_boot_protect cfg_store_checker i_chk (.clk, .reset, .tbl_rd,
    .tbl_wr, .tbl_addr, .tbl_rdata, .tbl_rvalid, .tbl_wack, .core_req,
    .core_addr, .core_cfg_reject, .flash_wr_req, .flash_wr_addr,
    .flash_wr_blocked, .boot_seg_present, .boot_seg_high_sec, .boot_seg_end,
    .boot_write_lock, .cfg_words);
`default_nettype wire
